/* include/asrs_pkg.sv */
`default_nettype none
package asrs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CHAR_W = 9;
	localparam int HIST_W = 10;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	// control field positions
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_NINE = 1;
	localparam int CTRL_MUTE = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// status field positions
	localparam int STAT_FULL = 0;
	localparam int STAT_OVERRUN = 1;
	localparam int STAT_NOISE = 2;
	localparam int STAT_FRAMING = 3;
	localparam int STAT_BREAK = 4;
	localparam int STAT_BUSY = 5;
	// sample phases within one bit time
	localparam logic [4:0] PH_FIRST = 5'h01;
	localparam logic [4:0] PH_SECOND = 5'h02;
	localparam logic [4:0] PH_V3 = 5'h03;
	localparam logic [4:0] PH_V5 = 5'h05;
	localparam logic [4:0] PH_V7 = 5'h07;
	localparam logic [4:0] PH_D8 = 5'h08;
	localparam logic [4:0] PH_D9 = 5'h09;
	localparam logic [4:0] PH_D10 = 5'h0A;
	localparam logic [4:0] PH_F14 = 5'h0E;
	localparam logic [4:0] PH_LAST = 5'h10;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SEARCH = 3'b001,
		ST_VERIFY = 3'b010,
		ST_DATA = 3'b011,
		ST_STOP = 3'b100,
		ST_RECOVER = 3'b101
	} asrs_state_e;

	typedef struct packed {
		logic qualify;
		logic fallEdge;
	} asrs_edge_s;

	typedef struct packed {
		logic reject;
		logic value;
		logic noise;
		logic startNoise;
	} asrs_vote_s;

	typedef struct packed {
		logic brk;
		logic framing;
		logic noise;
		logic overrun;
		logic full;
	} asrs_flags_s;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction
endpackage
`default_nettype wire

/* rtl/asrs_history.sv */
`default_nettype none
module asrs_history (
	input wire logic sys_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic tick, // one sample per pulse
	input wire logic sample, // serial line sample
	input wire logic forceOne, // shift a one instead of the line
	output asrs_pkg::asrs_edge_s edges // qualifier and resync pattern
);
	logic [asrs_pkg::HIST_W-2:0] hist_reg;
	logic eff;
	logic [asrs_pkg::HIST_W-1:0] win;

	assign eff = forceOne | sample;
	assign win = {hist_reg, eff};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hist_reg <= '0;
		end else if (tick) begin
			hist_reg <= win[asrs_pkg::HIST_W-2:0];
		end
	end

	// newest sample in bit 0; three ones then a low
	assign edges.qualify = win[3] & win[2] & win[1] & !win[0];
	// 111 0 d 0 d 0 d 0 with at most one high among RT3, RT5, RT7
	assign edges.fallEdge = win[9] & win[8] & win[7] & !win[6]
		& !asrs_pkg::maj3(win[4], win[2], win[0]);
endmodule
`default_nettype wire

/* rtl/asrs_vote.sv */
`default_nettype none
module asrs_vote (
	input wire logic sys_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic tick, // one sample per pulse
	input wire logic [4:0] phase, // phase of the current sample
	input wire logic sample, // serial line sample
	input wire logic clear, // drop partial data samples
	output asrs_pkg::asrs_vote_s vote // decisions on the current sample
);
	logic v3_reg;
	logic v5_reg;
	logic v7_reg;
	logic d8_reg;
	logic d9_reg;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			v3_reg <= 1'b0;
			v5_reg <= 1'b0;
			v7_reg <= 1'b0;
		end else if (tick) begin
			if (phase == asrs_pkg::PH_V3) begin
				v3_reg <= sample;
			end
			if (phase == asrs_pkg::PH_V5) begin
				v5_reg <= sample;
			end
			if (phase == asrs_pkg::PH_V7) begin
				v7_reg <= sample;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			d8_reg <= 1'b0;
			d9_reg <= 1'b0;
		end else if (clear) begin
			d8_reg <= 1'b0;
			d9_reg <= 1'b0;
		end else if (tick) begin
			if (phase == asrs_pkg::PH_D8) begin
				d8_reg <= sample;
			end
			if (phase == asrs_pkg::PH_D9) begin
				d9_reg <= sample;
			end
		end
	end

	// valid only on the tick of phase seven (reject) or phase ten (others)
	assign vote.reject = asrs_pkg::maj3(v3_reg, v5_reg, sample);
	assign vote.value = asrs_pkg::maj3(d8_reg, d9_reg, sample);
	assign vote.noise = !((d8_reg == d9_reg) && (d9_reg == sample));
	// start bit: RT1 was low, so any high among the six later samples disagrees
	assign vote.startNoise = v3_reg | v5_reg | v7_reg | d8_reg | d9_reg | sample;
endmodule
`default_nettype wire

/* rtl/async_serial_rx_sampler.sv */
`default_nettype none
module async_serial_rx_sampler (
	input wire logic sys_clk, // 125 MHz system clock
	input wire logic rst_b, // async reset, active low
	input wire logic sampleTick, // one pulse per sixteenth of a bit
	input wire logic rxLine, // serial input, synchronous to sys_clk
	input wire logic [asrs_pkg::ADDR_W-1:0] regAddr, // register byte address
	input wire logic [asrs_pkg::DATA_W-1:0] regWrData, // register write data
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	output logic [asrs_pkg::DATA_W-1:0] regRdData, // read data, cycle after strobe
	output logic receiveFull // receive buffer holds a character
);
	asrs_pkg::asrs_state_e state_reg;
	asrs_pkg::asrs_state_e state_next;
	logic [4:0] phase_reg;
	logic [4:0] phase_next;
	logic [3:0] bitCount_reg;
	logic [asrs_pkg::CHAR_W-1:0] shift_reg;
	logic [asrs_pkg::CHAR_W-1:0] buffer_reg;
	logic [2:0] ctrl_reg;
	logic enablePrev_reg;
	logic workNoise_reg;
	asrs_pkg::asrs_flags_s flags;
	logic full_reg;
	logic overrun_reg;
	logic noise_reg;
	logic framing_reg;
	logic brk_reg;
	logic flagEvent;
	logic charLoad;
	logic ctrlWrite;
	logic ctrlRead;
	logic statusRead;
	logic [asrs_pkg::DATA_W-1:0] statusWord;
	asrs_pkg::asrs_edge_s edges;
	asrs_pkg::asrs_vote_s vote;
	logic rxEnable;
	logic nineBit;
	logic wakeupMute;
	logic tick;
	logic forceOne;
	logic resync;
	logic frameDone;
	logic stopValue;
	logic [asrs_pkg::CHAR_W-1:0] rxChar;
	logic charZero;
	logic isBreak;
	logic charNoise;
	logic dataRead;
	logic [3:0] bitsWanted;

	assign rxEnable = ctrl_reg[asrs_pkg::CTRL_ENABLE];
	assign nineBit = ctrl_reg[asrs_pkg::CTRL_NINE];
	assign wakeupMute = ctrl_reg[asrs_pkg::CTRL_MUTE];
	// sampling is paced by the external 16x tick, not by sys_clk
	assign tick = sampleTick && rxEnable;
	assign bitsWanted = nineBit ? asrs_pkg::BITS_NINE : asrs_pkg::BITS_EIGHT;

	// artificial stop-bit ones only in the recovery tail
	assign forceOne = (state_reg == asrs_pkg::ST_RECOVER)
		&& (phase_reg >= asrs_pkg::PH_F14);

	asrs_history u_history (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick(tick),
		.sample(rxLine),
		.forceOne(forceOne),
		.edges(edges)
	);

	asrs_vote u_vote (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick(tick),
		.phase(phase_reg),
		.sample(rxLine),
		.clear(resync),
		.vote(vote)
	);

	// realign only inside the frame body; the start bit is already aligned
	assign resync = tick && edges.fallEdge
		&& ((state_reg == asrs_pkg::ST_DATA) || (state_reg == asrs_pkg::ST_STOP));

	assign frameDone = tick && (state_reg == asrs_pkg::ST_STOP)
		&& (phase_reg == asrs_pkg::PH_D10) && !resync;
	assign stopValue = vote.value;
	assign rxChar = nineBit ? shift_reg : {1'b0, shift_reg[asrs_pkg::CHAR_W-1:1]};
	assign charZero = (rxChar == '0);
	assign isBreak = !stopValue && charZero;
	assign charNoise = workNoise_reg || vote.noise;
	function automatic logic regHit(input logic [asrs_pkg::ADDR_W-1:0] addr,
		input logic [7:0] offset);
		return addr == offset;
	endfunction

	// one packing of the status word keeps the read mux and the bit layout together
	function automatic logic [asrs_pkg::DATA_W-1:0] packStatus(input asrs_pkg::asrs_flags_s f,
		input logic inFrame);
		logic [asrs_pkg::DATA_W-1:0] w;
		w = '0;
		w[asrs_pkg::STAT_FULL] = f.full;
		w[asrs_pkg::STAT_OVERRUN] = f.overrun;
		w[asrs_pkg::STAT_NOISE] = f.noise;
		w[asrs_pkg::STAT_FRAMING] = f.framing;
		w[asrs_pkg::STAT_BREAK] = f.brk;
		w[asrs_pkg::STAT_BUSY] = inFrame;
		return w;
	endfunction

	assign dataRead = regRead && regHit(regAddr, asrs_pkg::REG_DATA);
	assign statusRead = regRead && regHit(regAddr, asrs_pkg::REG_STATUS);
	assign ctrlRead = regRead && regHit(regAddr, asrs_pkg::REG_CTRL);
	assign ctrlWrite = regWrite && regHit(regAddr, asrs_pkg::REG_CTRL);
	// finished character, unless the mute bit keeps every flag quiet
	assign flagEvent = frameDone && !wakeupMute;
	assign charLoad = flagEvent && !full_reg;
	assign flags = {brk_reg, framing_reg, noise_reg, overrun_reg, full_reg};
	assign statusWord = packStatus(flags, enablePrev_reg
		&& (state_reg != asrs_pkg::ST_SEARCH) && (state_reg != asrs_pkg::ST_OFF));

	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		if (!rxEnable) begin
			state_next = asrs_pkg::ST_OFF;
			phase_next = asrs_pkg::PH_FIRST;
		end else if (state_reg == asrs_pkg::ST_OFF) begin
			state_next = asrs_pkg::ST_SEARCH;
			phase_next = asrs_pkg::PH_FIRST;
		end else if (tick) begin
			if (phase_reg == asrs_pkg::PH_LAST) begin
				phase_next = asrs_pkg::PH_FIRST;
			end else begin
				phase_next = phase_reg + 5'h01;
			end
			case (state_reg)
				asrs_pkg::ST_SEARCH: begin
					if (edges.qualify) begin
						state_next = asrs_pkg::ST_VERIFY;
						phase_next = asrs_pkg::PH_SECOND;
					end else begin
						phase_next = asrs_pkg::PH_FIRST;
					end
				end
				asrs_pkg::ST_VERIFY: begin
					if (phase_reg == asrs_pkg::PH_V7 && vote.reject) begin
						state_next = asrs_pkg::ST_SEARCH;
						phase_next = asrs_pkg::PH_FIRST;
					end else if (phase_reg == asrs_pkg::PH_LAST) begin
						state_next = asrs_pkg::ST_DATA;
					end
				end
				asrs_pkg::ST_DATA: begin
					if (resync) begin
						phase_next = asrs_pkg::PH_D8;
					end else if (phase_reg == asrs_pkg::PH_LAST && bitCount_reg == bitsWanted) begin
						state_next = asrs_pkg::ST_STOP;
					end
				end
				asrs_pkg::ST_STOP: begin
					if (resync) begin
						phase_next = asrs_pkg::PH_D8;
					end else if (frameDone) begin
						if (!stopValue && !isBreak) begin
							state_next = asrs_pkg::ST_RECOVER;
						end else begin
							state_next = asrs_pkg::ST_SEARCH;
							phase_next = asrs_pkg::PH_FIRST;
						end
					end
				end
				asrs_pkg::ST_RECOVER: begin
					if (phase_reg == asrs_pkg::PH_LAST) begin
						state_next = asrs_pkg::ST_SEARCH;
					end
				end
				default: begin
					state_next = asrs_pkg::ST_SEARCH;
					phase_next = asrs_pkg::PH_FIRST;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= asrs_pkg::ST_OFF;
			phase_reg <= asrs_pkg::PH_FIRST;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
		end
	end

	// data bits shift in from the top so the first bit ends at the bottom
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_reg <= '0;
			bitCount_reg <= 4'h0;
		end else if (tick && state_reg == asrs_pkg::ST_VERIFY) begin
			bitCount_reg <= 4'h0;
		end else if (tick && state_reg == asrs_pkg::ST_DATA && phase_reg == asrs_pkg::PH_D10
				&& !resync) begin
			shift_reg <= {vote.value, shift_reg[asrs_pkg::CHAR_W-1:1]};
			bitCount_reg <= bitCount_reg + 4'h1;
		end
	end

	// working noise for the character in flight
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			workNoise_reg <= 1'b0;
		end else if (tick && state_reg == asrs_pkg::ST_SEARCH && edges.qualify) begin
			workNoise_reg <= 1'b0;
		end else if (tick && phase_reg == asrs_pkg::PH_D10) begin
			if (state_reg == asrs_pkg::ST_VERIFY) begin
				// start value is forced low, so the six highs are the disagreement
				workNoise_reg <= workNoise_reg | vote.startNoise;
			end else if (state_reg == asrs_pkg::ST_DATA && !resync) begin
				workNoise_reg <= workNoise_reg | vote.noise;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			buffer_reg <= '0;
		end else if (charLoad) begin
			buffer_reg <= rxChar;
		end
	end

	// hardware set wins over a clearing read in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			full_reg <= 1'b0;
		end else if (charLoad) begin
			full_reg <= 1'b1;
		end else if (dataRead && !flagEvent) begin
			full_reg <= 1'b0;
		end
	end

	// a discarded character leaves the buffered one and its flags alone
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			overrun_reg <= 1'b0;
		end else if (flagEvent && full_reg) begin
			overrun_reg <= 1'b1;
		end else if (dataRead) begin
			overrun_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			noise_reg <= 1'b0;
		end else if (charLoad) begin
			noise_reg <= charNoise;
		end else if (dataRead && !flagEvent) begin
			noise_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			framing_reg <= 1'b0;
		end else if (charLoad) begin
			framing_reg <= !stopValue;
		end else if (dataRead && !flagEvent) begin
			framing_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			brk_reg <= 1'b0;
		end else if (charLoad) begin
			brk_reg <= isBreak;
		end else if (dataRead && !flagEvent) begin
			brk_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= asrs_pkg::CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrl_reg <= regWrData[2:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			enablePrev_reg <= 1'b0;
		end else begin
			enablePrev_reg <= rxEnable;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= '0;
		end else if (!regRead) begin
			regRdData <= '0;
		end else if (ctrlRead) begin
			regRdData <= {13'h0000, ctrl_reg};
		end else if (statusRead) begin
			regRdData <= statusWord;
		end else if (dataRead) begin
			regRdData <= {7'h00, buffer_reg};
		end else begin
			regRdData <= '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			receiveFull <= 1'b0;
		end else begin
			receiveFull <= full_reg;
		end
	end
endmodule
`default_nettype wire

/* testbench/asrs_asserts.sv */
`default_nettype none
module asrs_asserts (
	input wire logic sys_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic sampleTick, // sample pulse
	input wire logic rxLine, // serial input
	input wire logic [7:0] regAddr, // register address
	input wire logic [15:0] regWrData, // write data
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	input wire logic [15:0] regRdData, // read data
	input wire logic receiveFull // buffer full
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic dRd = regRead && regAddr == asrs_pkg::REG_DATA;
	wire logic sRd = regRead && regAddr == asrs_pkg::REG_STATUS;
	wire logic cWr = regWrite && regAddr == asrs_pkg::REG_CTRL;
	wire logic cRd = regRead && regAddr == asrs_pkg::REG_CTRL;
	wire logic uRd = regRead && !dRd && !sRd && !cRd;
	logic muteReg;
	// shadow of the mute bit, the only control state this checker tracks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) muteReg <= 1'b0;
		else if (cWr) muteReg <= regWrData[asrs_pkg::CTRL_MUTE];
	end
	a_idle_read_zero: assert property (!regRead |=> regRdData == 16'h0000)
		else $error("read data not zero without a read");
	a_unmapped_zero: assert property (uRd |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	a_status_upper: assert property (sRd |=> regRdData[15:6] == 10'h000)
		else $error("status spare bits set");
	a_data_upper: assert property (dRd |=> regRdData[15:9] == 7'h00)
		else $error("data spare bits set");
	a_ctrl_back: assert property (cWr ##2 cRd |=> regRdData == {13'h0, $past(regWrData[2:0], 3)})
		else $error("control readback wrong");
	a_full_cause: assert property ($rose(receiveFull) |-> $past(sampleTick, 2))
		else $error("full rose without a sample");
	a_full_hold: assert property ($fell(receiveFull) |-> $past(dRd, 2))
		else $error("full dropped without data read");
	a_full_clear: assert property (dRd && !sampleTick ##1 !sampleTick |=> !receiveFull)
		else $error("full kept after data read");
	a_mute_quiet: assert property ($rose(receiveFull) |-> !$past(muteReg, 2))
		else $error("full set while muted");
	cover property ($rose(receiveFull));
	cover property (dRd ##1 regRdData != 16'h0000);
	cover property (uRd);
endmodule
bind async_serial_rx_sampler asrs_asserts chk_u (.sys_clk, .rst_b, .sampleTick, .rxLine,
	.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .receiveFull);
`default_nettype wire

/* testbench/asrs_tx_model.sv */
`default_nettype none
module asrs_tx_model (
	input wire logic sys_clk, // system clock
	input wire logic sampleTick, // sixteenth of a bit
	input wire logic go, // start one frame
	input wire logic [8:0] data, // character
	input wire logic nine, // nine data bits
	input wire logic stopBit, // low gives a framing error
	input wire logic [15:0] lead, // idle ticks before the start bit
	input wire logic [15:0] flip, // tick inverted as noise
	output logic txLine, // serial out, idle high
	output logic busy // frame running
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] pos = 16'h0000;
	logic [15:0] k;
	logic [11:0] bits;
	initial txLine = 1'b1;
	initial busy = 1'b0;
	assign k = (pos - lead) >> 4;
	assign bits = nine ? {1'b1, stopBit, data, 1'b0} : {2'h3, stopBit, data[7:0], 1'b0};
	always @(posedge sys_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			pos <= 16'h0000;
		end else if (busy && sampleTick) begin
			pos <= pos + 16'h0001;
			if (pos < lead) txLine <= (pos != flip);
			else if (k <= (nine ? 16'hA : 16'h9)) txLine <= bits[k] ^ (pos == flip);
			else begin
				txLine <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/async_serial_rx_sampler_tb.sv */
`default_nettype none
module async_serial_rx_sampler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CT = asrs_pkg::REG_CTRL;
	localparam logic [7:0] ST = asrs_pkg::REG_STATUS;
	localparam logic [7:0] DT = asrs_pkg::REG_DATA;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic sampleTick = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic go = 1'b0;
	logic nine = 1'b0;
	logic stopBit = 1'b1;
	logic rxLine, receiveFull, busy;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000;
	logic [15:0] regRdData;
	logic [8:0] txData = 9'h000;
	logic [15:0] lead = 16'h0000;
	logic [15:0] flip = 16'hFFFF;
	logic [1:0] tDiv = 2'h0;
	int n_mismatch = 0;
	int num_checks = 0;
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		tDiv <= tDiv + 2'h1;
		sampleTick <= (tDiv == 2'h3);
	end
	async_serial_rx_sampler dut_u (.sys_clk, .rst_b, .sampleTick, .rxLine, .regAddr,
		.regWrData, .regWrite, .regRead, .regRdData, .receiveFull);
	asrs_tx_model tx_u (.sys_clk, .sampleTick, .go, .data(txData), .nine, .stopBit,
		.lead, .flip, .txLine(rxLine), .busy);
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk(regRdData, exp);
		@(posedge sys_clk);
	endtask
	// the far side never stalls, so a frame that outlives the bound is a hang
	task automatic frame(input logic [8:0] d, input logic [15:0] ld, input logic [15:0] fl,
		input logic sb);
		txData <= d;
		lead <= ld;
		flip <= fl;
		stopBit <= sb;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		for (int k = 0; k < 30000 && busy; k++) @(posedge sys_clk);
		if (busy) begin
			n_mismatch++;
			$display("BAD %0t frame hung", $time);
			final_report();
		end
		repeat (4) @(posedge sys_clk);
	endtask
	function automatic logic [15:0] st(input logic [4:0] f);
		return {11'h000, f};
	endfunction
	task automatic want(input logic [8:0] c, input logic [15:0] s);
		chk({15'h0000, receiveFull}, {15'h0000, s[0]});
		rc(ST, s);
		if (s[0]) rc(DT, {7'h00, c});
		rc(ST, 16'h0000);
		chk({15'h0000, receiveFull}, 16'h0000);
	endtask
	initial begin
		int seed;
		logic [8:0] c;
		seed = $urandom(12);
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rc(CT, 16'h0000);
		wr(CT, 16'h0001);
		rc(CT, 16'h0001);
		rc(8'h0C, 16'h0000);
		wr(ST, 16'hFFFF);
		rc(ST, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			if (i == 6) wr(CT, 16'h0003);
			nine <= (i >= 6);
			c = (i >= 6) ? 9'($urandom) : {1'b0, 8'($urandom)};
			frame(c, 16'h0008 + 16'($urandom % 16), 16'hFFFF, 1'b1);
			want(c, st(5'h01));
		end
		wr(CT, 16'h0001);
		nine <= 1'b0;
		frame(9'h0A5, 16'h0008, 16'h0008 + 16'd56, 1'b1);
		want(9'h0A5, st(5'h05));
		frame(9'h03C, 16'h0008, 16'h0010, 1'b1);
		want(9'h03C, st(5'h05));
		frame(9'h0C3, 16'h0028, 16'h0020, 1'b1);
		want(9'h0C3, st(5'h01));
		// second frame follows the bad stop bit with almost no idle time
		frame(9'h05A, 16'h0008, 16'hFFFF, 1'b0);
		frame(9'h011, 16'h0000, 16'hFFFF, 1'b1);
		want(9'h05A, st(5'h0B));
		frame(9'h000, 16'h0008, 16'hFFFF, 1'b0);
		want(9'h000, st(5'h19));
		frame(9'h07E, 16'h0010, 16'hFFFF, 1'b1);
		want(9'h07E, st(5'h01));
		wr(CT, 16'h0005);
		frame(9'h0F0, 16'h0008, 16'hFFFF, 1'b1);
		want(9'h0F0, 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
